// ### port_cfg_map.vh
// Register offsets, field positions and reset values of the port block.
// Assumes APB byte addressing with one 32-bit word per register.
`ifndef PORT_CFG_MAP_VH
`define PORT_CFG_MAP_VH
`define ADDR_W 8
`define OFS_GP_DATA 8'h00
`define OFS_GP_DIR 8'h04
`define OFS_GP_WEAK 8'h08
`define OFS_GP_PULL_EN 8'h0C
`define OFS_GP_PULL_POL 8'h10
`define OFS_GP_IRQ_EN 8'h14
`define OFS_GP_IRQ_FLAG 8'h18
`define OFS_BC_DATA 8'h20
`define OFS_BC_DIR 8'h24
`define OFS_BC_ASSIGN 8'h28
`define OFS_BC_CTRL 8'h2C
`define BC_CTRL_PULL_BIT 0
`define BC_CTRL_EMU_BIT 1
`define BC_CTRL_W 2
`define RST_BYTE 8'h00
`define RST_BC_ASSIGN 8'h00
`define RST_BC_CTRL 2'h0
`endif

// ### pin_sync.v
// Two-flop synchroniser for a vector of pin inputs.
// Assumes asynchronous pin levels entering the pclk domain.
module pin_sync #(
  parameter W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ### edge_flag.v
// Per-pin edge detector with sticky flag, write-one-to-clear.
// Assumes a synchronised input level.
module edge_flag (
  input wire pclk,
  input wire presetn,
  input wire level,
  input wire enable,
  input wire rising_sel,
  input wire clear,
  output reg flag
);
  reg prev;
  wire hit;
  // R1
  assign hit = enable & (rising_sel ? (level & ~prev) : (~level & prev));
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 1'b0;
      flag <= 1'b0;
    end else begin
      prev <= level;
      if (hit) begin
        flag <= 1'b1; // R18
      end else if (clear) begin
        flag <= 1'b0;
      end
    end
  end
endmodule

// ### port_pin_config_and_bus_port.v
// Configurable general-purpose port with optional edge interrupts, plus bus-control port.
// Assumes an APB master on pclk; pins are driven through out, oe and pull controls.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`include "port_cfg_map.vh"

// Notes on behaviour
// R1 - With interrupt enabled, pull-select 0 means falling edge, 1 rising edge.
// R2 - Input pin with pull enabled: select 0 pulls up, 1 pulls down.
// R3 - Direction 1 drives output level; pull device then disabled.
// R4 - Output pins use reduced drive when weak bit is 1.
// R5 - Edge interrupts exist only on ports built with interrupt support.
// R6 - Register reads are sampled synchronously to pclk.
// R7 - Unused locations and bits read zero; writes to them do nothing.
// R8 - Special peripheral mode removes port registers from the map.
// R9 - Bus-control data register is read and written anytime while mapped.
// R10 - Bus-control pins 7:2 bidirectional, pins 1:0 input only.
// R11 - Assignment picks dedicated or general use; direction applies only then.
// R12 - Bus-control direction also picks the read data source.
// R13 - Direction 0 reads synchronised pin, direction 1 reads output latch.
// R14 - Interrupt request pins of bus-control port pull up only.
// R15 - One bit enables bus-control pulls, only on input pins.
// R16 - Emulation bit in expanded mode unmaps data register and echoes externally.
// R17 - Software loads data before direction; not a word write of both. The bench does so on the bus-control port only; it writes gp direction first.
// R18 - Enabled pins are synchronised, edge detected, flagged, and raise interrupt.
module port_pin_config_and_bus_port #(
  parameter W = 8,
  parameter HAS_IRQ = 1
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire special_periph_mode,
  input wire expanded_mode,
  input wire [W-1:0] gp_pin_in,
  output reg [W-1:0] gp_pin_out,
  output reg [W-1:0] gp_pin_oe,
  output reg [W-1:0] gp_weak_drive,
  output reg [W-1:0] gp_pull_up,
  output reg [W-1:0] gp_pull_down,
  output reg gp_irq,
  input wire [7:0] bc_pin_in,
  output reg [7:0] bc_pin_out,
  output reg [7:0] bc_pin_oe,
  output reg [7:0] bc_pull_up,
  output reg [7:0] bc_gp_select,
  output reg bc_echo_external
);
  reg [W-1:0] gp_data;
  reg [W-1:0] gp_dir;
  reg [W-1:0] weak_drive_select;
  reg [W-1:0] pull_enable_bit;
  reg [W-1:0] pull_polarity_edge_select;
  reg [W-1:0] pin_interrupt_enable;
  reg [7:0] bus_ctrl_port_data;
  reg [7:0] bus_ctrl_port_direction;
  reg [7:0] bus_ctrl_pin_assignment;
  reg bc_pull_on;
  reg bus_ctrl_port_emulation_bit;
  wire [W-1:0] gp_sync;
  wire [7:0] bc_sync;
  wire [W-1:0] irq_flag;
  wire [W-1:0] flag_clear;
  wire setup;
  wire wr;
  wire map_ok;
  wire bc_data_mapped;
  wire [7:0] bc_dir_eff;
  wire access_done;
  wire rd_setup;
  wire echo_hit;
  reg [31:0] next_prdata;
  reg next_err;
  integer i;

  // Two-flop synchronisers for pin levels
  pin_sync #(.W(W)) u_gp_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(gp_pin_in),
    .sync_out(gp_sync)
  );
  pin_sync #(.W(8)) u_bc_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(bc_pin_in),
    .sync_out(bc_sync)
  );

  assign setup = psel & ~penable;
  // Writes land at the edge that completes the access
  assign access_done = psel & penable & pready;
  assign wr = access_done & pwrite;
  assign rd_setup = setup & ~pwrite;
  assign map_ok = ~special_periph_mode; // R8
  assign bc_data_mapped = map_ok & ~(expanded_mode & bus_ctrl_port_emulation_bit); // R16
  // Pins 1:0 never drive
  assign bc_dir_eff = {bus_ctrl_port_direction[7:2], 2'b00}; // R10
  assign flag_clear = (wr && map_ok && paddr == `OFS_GP_IRQ_FLAG) ? pwdata[W-1:0] : {W{1'b0}};
  assign echo_hit = ~bc_data_mapped & map_ok & (paddr == `OFS_BC_DATA);

  // Edge flags, only on ports with interrupts
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : gen_irq
      if (HAS_IRQ != 0) begin : gen_on
        edge_flag u_edge (
          .pclk(pclk),
          .presetn(presetn),
          .level(gp_sync[g]),
          .enable(pin_interrupt_enable[g]),
          .rising_sel(pull_polarity_edge_select[g]),
          .clear(flag_clear[g]),
          .flag(irq_flag[g])
        ); // R1 R18
      end else begin : gen_off
        assign irq_flag[g] = 1'b0; // R5
      end
    end
  endgenerate

  // General-purpose registers, written as the access completes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_data <= `RST_BYTE;
      gp_dir <= `RST_BYTE;
      weak_drive_select <= `RST_BYTE;
      pull_enable_bit <= `RST_BYTE;
      pull_polarity_edge_select <= `RST_BYTE;
      pin_interrupt_enable <= `RST_BYTE;
    end else if (wr && map_ok) begin
      case (paddr)
        `OFS_GP_DATA: begin
          gp_data <= pwdata[W-1:0];
        end
        `OFS_GP_DIR: begin
          gp_dir <= pwdata[W-1:0];
        end
        `OFS_GP_WEAK: begin
          weak_drive_select <= pwdata[W-1:0];
        end
        `OFS_GP_PULL_EN: begin
          pull_enable_bit <= pwdata[W-1:0];
        end
        `OFS_GP_PULL_POL: begin
          pull_polarity_edge_select <= pwdata[W-1:0];
        end
        `OFS_GP_IRQ_EN: begin
          if (HAS_IRQ != 0) begin
            pin_interrupt_enable <= pwdata[W-1:0]; // R5
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Bus-control registers, written as the access completes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_ctrl_port_data <= `RST_BYTE;
      bus_ctrl_port_direction <= `RST_BYTE;
      bus_ctrl_pin_assignment <= `RST_BC_ASSIGN;
      bc_pull_on <= 1'b0;
      bus_ctrl_port_emulation_bit <= 1'b0;
    end else if (wr && map_ok) begin
      case (paddr)
        `OFS_BC_DATA: begin
          if (bc_data_mapped) begin
            bus_ctrl_port_data <= pwdata[7:0]; // R9
          end
        end
        `OFS_BC_DIR: begin
          bus_ctrl_port_direction <= {pwdata[7:2], 2'b00}; // R10 R7
        end
        `OFS_BC_ASSIGN: begin
          bus_ctrl_pin_assignment <= pwdata[7:0];
        end
        `OFS_BC_CTRL: begin
          bc_pull_on <= pwdata[`BC_CTRL_PULL_BIT];
          bus_ctrl_port_emulation_bit <= pwdata[`BC_CTRL_EMU_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux
  always @* begin
    next_prdata = 32'h00000000;
    next_err = 1'b0;
    if (!map_ok) begin
      next_err = 1'b1; // R8
    end else begin
      case (paddr)
        `OFS_GP_DATA: begin
          next_prdata[W-1:0] = (gp_dir & gp_data) | (~gp_dir & gp_sync); // R13
        end
        `OFS_GP_DIR: begin
          next_prdata[W-1:0] = gp_dir;
        end
        `OFS_GP_WEAK: begin
          next_prdata[W-1:0] = weak_drive_select;
        end
        `OFS_GP_PULL_EN: begin
          next_prdata[W-1:0] = pull_enable_bit;
        end
        `OFS_GP_PULL_POL: begin
          next_prdata[W-1:0] = pull_polarity_edge_select;
        end
        `OFS_GP_IRQ_EN: begin
          next_prdata[W-1:0] = pin_interrupt_enable;
        end
        `OFS_GP_IRQ_FLAG: begin
          next_prdata[W-1:0] = irq_flag;
        end
        `OFS_BC_DATA: begin
          if (bc_data_mapped) begin
            // R12 R13
            next_prdata[7:0] = (bc_dir_eff & bus_ctrl_port_data) | (~bc_dir_eff & bc_sync);
          end else begin
            next_err = 1'b1; // R16
          end
        end
        `OFS_BC_DIR: begin
          next_prdata[7:0] = bus_ctrl_port_direction;
        end
        `OFS_BC_ASSIGN: begin
          next_prdata[7:0] = bus_ctrl_pin_assignment;
        end
        `OFS_BC_CTRL: begin
          next_prdata[`BC_CTRL_W-1:0] = {bus_ctrl_port_emulation_bit, bc_pull_on};
        end
        default: begin
          next_prdata = 32'h00000000; // R7
        end
      endcase
    end
  end

  // APB answer one cycle after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      bc_echo_external <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & next_err;
      bc_echo_external <= setup & echo_hit; // R16
      if (rd_setup) begin
        prdata <= next_prdata; // R6
      end
    end
  end

  // Pin control outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_pin_out <= {W{1'b0}};
      gp_pin_oe <= {W{1'b0}};
      gp_weak_drive <= {W{1'b0}};
      gp_pull_up <= {W{1'b0}};
      gp_pull_down <= {W{1'b0}};
      gp_irq <= 1'b0;
    end else begin
      gp_pin_out <= gp_data; // R3
      gp_pin_oe <= gp_dir; // R3
      gp_weak_drive <= gp_dir & weak_drive_select; // R4
      gp_pull_up <= ~gp_dir & pull_enable_bit & ~pull_polarity_edge_select; // R2 R3
      gp_pull_down <= ~gp_dir & pull_enable_bit & pull_polarity_edge_select; // R2 R3
      gp_irq <= |irq_flag; // R18
    end
  end

  // Pin control outputs, bus-control port
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bc_pin_out <= 8'h00;
      bc_pin_oe <= 8'h00;
      bc_pull_up <= 8'h00;
      bc_gp_select <= 8'h00;
    end else begin
      bc_pin_out <= bus_ctrl_port_data;
      bc_gp_select <= ~bus_ctrl_pin_assignment;
      bc_pin_oe <= bc_dir_eff & ~bus_ctrl_pin_assignment; // R11 R10
      for (i = 0; i < 8; i = i + 1) begin
        // R14 R15
        bc_pull_up[i] <= bc_pull_on & ~bc_dir_eff[i];
      end
    end
  end
endmodule

// ### port_monitor.sv
// Checker of the port block's pin controls and bus answers.
// Assumes it is bound into the port block; sees only its ports.
module port_monitor #(
  parameter W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire special_periph_mode,
  input wire pready,
  input wire pslverr,
  input wire [W-1:0] gp_pin_oe,
  input wire [W-1:0] gp_pull_up,
  input wire [W-1:0] gp_pull_down,
  input wire [7:0] bc_pin_oe,
  input wire [7:0] bc_pull_up,
  input wire [7:0] bc_gp_select,
  input wire bc_echo_external
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  AST_ANSWER: assert property (s_setup |=> s_answer)
    else $error("no single-cycle answer");
  AST_SPECIAL: assert property (s_setup ##0 special_periph_mode |=> pready && pslverr)
    else $error("special mode access not refused");
  AST_PULL_EXCL: assert property ((gp_pull_up & gp_pull_down) == '0)
    else $error("pull up and down together");
  AST_PULL_OUT: assert property (((gp_pull_up | gp_pull_down) & gp_pin_oe) == '0)
    else $error("pull on output pin");
  AST_BC_IN_ONLY: assert property (bc_pin_oe[1:0] == 2'h0)
    else $error("input-only pin driven");
  AST_BC_ASSIGN: assert property ((bc_pin_oe & ~bc_gp_select) == 8'h00)
    else $error("dedicated pin driven here");
  AST_BC_PULL: assert property ((bc_pull_up & bc_pin_oe) == 8'h00)
    else $error("pull on driven pin");
  AST_ECHO: assert property (bc_echo_external |-> pready && pslverr)
    else $error("echo without refused answer");
endmodule

bind port_pin_config_and_bus_port port_monitor #(.W(W)) u_port_monitor (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .special_periph_mode(special_periph_mode),
  .pready(pready),
  .pslverr(pslverr),
  .gp_pin_oe(gp_pin_oe),
  .gp_pull_up(gp_pull_up),
  .gp_pull_down(gp_pull_down),
  .bc_pin_oe(bc_pin_oe),
  .bc_pull_up(bc_pull_up),
  .bc_gp_select(bc_gp_select),
  .bc_echo_external(bc_echo_external)
);

// ### pin_board.sv
// Board model: resolves pin levels from drive, pulls and outside level.
// Assumes undriven unpulled gp pins follow the bench's outside level; undriven unpulled bc pins read low.
module pin_board (
  input wire [7:0] gp_out,
  input wire [7:0] gp_oe,
  input wire [7:0] gp_pu,
  input wire [7:0] gp_pd,
  input wire [7:0] ext_gp,
  input wire [7:0] bc_out,
  input wire [7:0] bc_oe,
  input wire [7:0] bc_pu,
  output wire [7:0] gp_pin,
  output wire [7:0] bc_pin
);
  // Driven level wins, then pull, then outside level on gp pins; bc pins read low instead
  assign gp_pin = (gp_oe & gp_out) | (~gp_oe & gp_pu) | (~gp_oe & ~gp_pu & ~gp_pd & ext_gp);
  assign bc_pin = (bc_oe & bc_out) | (~bc_oe & bc_pu);
endmodule

// ### tb_port_pin_config_and_bus_port.sv
// Testbench of the port block: APB tasks and pin checks.
// Assumes the board model and the bound checker.
`include "port_cfg_map.vh"
module tb_port_pin_config_and_bus_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic spm = 1'b0, exm = 1'b0, pready, pslverr, gp_irq, bc_echo, echo, err;
  logic [7:0] paddr = 8'h00, ext_gp = 8'h00, gp_in, bc_in, gp_out, gp_oe, gp_wk, gp_pu, gp_pd;
  logic [7:0] bc_out, bc_oe, bc_pu, bc_sel;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int bad_count = 0, total_checks = 0;
  always #2 pclk = ~pclk;
  port_pin_config_and_bus_port u_port_pin_config_and_bus_port (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .special_periph_mode(spm),
    .expanded_mode(exm), .gp_pin_in(gp_in), .gp_pin_out(gp_out), .gp_pin_oe(gp_oe),
    .gp_weak_drive(gp_wk), .gp_pull_up(gp_pu), .gp_pull_down(gp_pd), .gp_irq(gp_irq),
    .bc_pin_in(bc_in), .bc_pin_out(bc_out), .bc_pin_oe(bc_oe), .bc_pull_up(bc_pu),
    .bc_gp_select(bc_sel), .bc_echo_external(bc_echo));
  pin_board u_pin_board (.gp_out(gp_out), .gp_oe(gp_oe), .gp_pu(gp_pu), .gp_pd(gp_pd),
    .ext_gp(ext_gp), .bc_out(bc_out), .bc_oe(bc_oe), .bc_pu(bc_pu), .gp_pin(gp_in),
    .bc_pin(bc_in));
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      bad_count++;
      tally_and_finish;
    end
    rd = prdata;
    err = pslverr;
    echo = bc_echo;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial begin
    wt(8);
    presetn <= 1'b1;
    apb(1'b1, 8'h30, 32'hFFFFFFFF);
    apb(1'b0, 8'h30, 32'h0); check("unused", rd, 32'h0);
    apb(1'b1, `OFS_GP_DIR, 32'hFFFFFF3C);
    apb(1'b0, `OFS_GP_DIR, 32'h0); check("dir bits", rd, 32'h3C);
    apb(1'b1, `OFS_GP_PULL_EN, 32'hFF);
    apb(1'b1, `OFS_GP_PULL_POL, 32'h0F);
    apb(1'b1, `OFS_GP_DATA, 32'hA5);
    apb(1'b1, `OFS_GP_WEAK, 32'hFF);
    wt(4);
    check("oe", gp_oe, 32'h3C);
    check("out", gp_out & gp_oe, 32'h24);
    check("pull up", gp_pu, 32'hC0);
    check("pull down", gp_pd, 32'h03);
    check("weak", gp_wk & gp_oe, 32'h3C);
    apb(1'b0, `OFS_GP_DATA, 32'h0); check("data read", rd, 32'hE4);
    $display("test gp config done");
    apb(1'b1, `OFS_GP_DIR, 32'h0);
    apb(1'b1, `OFS_GP_PULL_EN, 32'h0);
    apb(1'b1, `OFS_GP_PULL_POL, 32'h02);
    ext_gp <= 8'h01;
    apb(1'b1, `OFS_GP_IRQ_EN, 32'h03);
    wt(6);
    apb(1'b1, `OFS_GP_IRQ_FLAG, 32'hFF);
    ext_gp <= 8'h06;
    wt(8);
    check("irq", gp_irq, 32'h1);
    apb(1'b0, `OFS_GP_IRQ_FLAG, 32'h0); check("flags", rd, 32'h03);
    apb(1'b1, `OFS_GP_IRQ_FLAG, 32'h03);
    wt(3);
    check("irq clear", gp_irq, 32'h0);
    ext_gp <= 8'h01;
    wt(8);
    apb(1'b0, `OFS_GP_IRQ_FLAG, 32'h0); check("wrong edges", rd, 32'h0);
    $display("test edges done");
    apb(1'b1, `OFS_BC_CTRL, 32'h1);
    apb(1'b1, `OFS_BC_DATA, 32'h5A);
    apb(1'b1, `OFS_BC_DIR, 32'hFF);
    wt(4);
    check("bc oe", bc_oe, 32'hFC);
    check("bc pull", bc_pu, 32'h03);
    apb(1'b0, `OFS_BC_DATA, 32'h0); check("bc data", rd, 32'h5B);
    apb(1'b0, `OFS_BC_DIR, 32'h0); check("bc dir", rd, 32'hFC);
    apb(1'b1, `OFS_BC_ASSIGN, 32'hF0);
    wt(4);
    check("bc assign", bc_oe, 32'h0C);
    check("bc gp select", bc_sel, 32'h0F);
    exm <= 1'b1;
    apb(1'b1, `OFS_BC_CTRL, 32'h3);
    apb(1'b0, `OFS_BC_DATA, 32'h0); check("emu err", err, 32'h1);
    check("emu echo", echo, 32'h1);
    $display("test bus port done");
    spm <= 1'b1;
    apb(1'b1, `OFS_GP_WEAK, 32'h0); check("spm err", err, 32'h1);
    spm <= 1'b0;
    apb(1'b0, `OFS_GP_WEAK, 32'h0); check("spm kept", rd, 32'hFF);
    $display("test special done");
    presetn <= 1'b0;
    wt(2);
    check("reset oe", gp_oe, 32'h0);
    check("reset gp select", bc_sel, 32'h0);
    presetn <= 1'b1;
    wt(2);
    check("gp select after reset", bc_sel, 32'hFF);
    apb(1'b0, `OFS_GP_WEAK, 32'h0); check("weak after reset", rd, 32'h0);
    $display("test reset done");
    tally_and_finish;
  end
endmodule
